// *** dv/ext_mem_model.sv ***
// Far-side memory model: external acknowledge and data-drive behaviour.
`timescale 1ns/1ps
module ext_mem_model #(
    parameter int ACK_DELAY = 3
) (
    input wire logic clk_in,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic last_n_in,
    input wire logic last_mode_in,
    output logic ack_n_out,
    output logic drive_out
);
    int cnt;
    initial begin
        ack_n_out = 1'b1;
        drive_out = 1'b0;
        cnt = 0;
    end
    // ========================================================================
    // Handshake
    // ========================================================================
    // The device is slow on purpose, so the synchroniser path is exercised.
    always @(posedge clk_in) begin
        cnt <= (ce_n_in || cnt == ACK_DELAY) ? 0 : cnt + 1;
        ack_n_out <= !(!ce_n_in && cnt == ACK_DELAY);
    end
    // ========================================================================
    // Data lines
    // ========================================================================
    always @(posedge clk_in) begin
        if (!oe_n_in) begin
            drive_out <= 1'b1;
        end else if (last_mode_in ? !last_n_in : 1'b1) begin
            drive_out <= 1'b0;
        end
    end
endmodule // ext_mem_model

// *** dv/tb_top.sv ***
// Self-checking bench for the chip-select burst sequencer.
`timescale 1ns/1ps
module tb_top;
    localparam int K_ACK = 0, K_FIRST = 1, K_OE = 2, K_WE = 3, K_BD = 4;
    localparam int K_ST = 5, K_CE = 6, K_OEF = 7, K_CEF = 8, K_INH = 9;
    localparam int K_P16 = 10;
    logic clk_in, reset_n_in, last_sel, term, ext_ack_n, mem_drive;
    logic [8:0] cfg;
    cs_burst_pkg::access_req_t rq;
    logic ready, ce_n, oe_n, we_n, bd_n, st_n, ack_n, inhib, p16;
    logic cs_pins, type2, port32;
    logic [3:0] b_interface_type_field;
    logic [2:0] b_waits;
    int fails, n_compared, done;
    int m[11];
    chip_select_burst_interface u_chip_select_burst_interface (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .reset_config_in(cfg),
        .last_pin_select_in(last_sel), .req_valid_in(rq.valid),
        .req_write_in(rq.write), .req_burst_in(rq.burst),
        .req_boot_in(rq.boot), .interface_type_field_in(rq.interface_type_field),
        .req_burstable_in(rq.burstable), .req_small_port_in(rq.small_port),
        .internal_ack_enable_in(rq.ack_en), .req_waits_in(rq.waits),
        .ebi_terminate_in(term), .ext_ack_n_in(ext_ack_n),
        .req_ready_out(ready), .chip_enable_n_out(ce_n),
        .output_enable_n_out(oe_n), .write_enable_n_out(we_n),
        .burst_in_progress_n_out(bd_n), .transfer_start_n_out(st_n),
        .transfer_ack_n_out(ack_n), .burst_inhibit_out(inhib),
        .port16_out(p16), .cs_pins_select_out(cs_pins),
        .burst_type2_out(type2), .boot_interface_type_field_out(b_interface_type_field),
        .boot_port32_out(port32), .boot_waits_out(b_waits));
    ext_mem_model u_ext_mem_model (
        .clk_in(clk_in), .ce_n_in(ce_n), .oe_n_in(oe_n), .last_n_in(bd_n),
        .last_mode_in(last_sel), .ack_n_out(ext_ack_n),
        .drive_out(mem_drive));
    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    // Flags are {write, burst, boot, burstable, small_port}.
    function automatic cs_burst_pkg::access_req_t mk(input logic [4:0] f,
        input logic [3:0] it, input logic ae, input logic [2:0] ws);
        return '{1'b1, f[4], f[3], f[2], it, f[1], f[0], ae, ws};
    endfunction
    task automatic do_reset(input logic [8:0] c);
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        cfg <= c;
        repeat (20) @(posedge clk_in);
        #1;
        check({ce_n, oe_n, we_n, st_n, ack_n}, 5'h1F);
        check({cs_pins, type2, b_interface_type_field, port32, b_waits}, 10'h217);
        @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        check(cs_pins, c[cs_burst_pkg::CFG_PIN_FN]);
        check(type2, c[cs_burst_pkg::CFG_BURST_TYPE]);
        check(b_interface_type_field, c[3] ? 4'h1 : 4'h8);
        check(port32, c[cs_burst_pkg::CFG_BOOT_PORT]);
        check(b_waits, c[8:6]);
    endtask
    // Counts, per cycle after the request is taken, what each strobe did.
    task automatic access(input cs_burst_pkg::access_req_t r, input int t_at);
        int n;
        m = '{default: 0};
        n = 0;
        @(posedge clk_in);
        rq <= r;
        @(posedge clk_in);
        rq.valid <= 1'b0;
        do begin
            #1;
            n++;
            if (!ack_n && m[K_FIRST] == 0) m[K_FIRST] = n;
            if (!oe_n && m[K_OEF] == 0) m[K_OEF] = n;
            if (!ce_n && m[K_CEF] == 0) m[K_CEF] = n;
            m[K_ACK] += !ack_n;
            m[K_OE] += !oe_n;
            m[K_WE] += !we_n;
            m[K_BD] += !bd_n;
            m[K_ST] += !st_n;
            m[K_CE] += !ce_n;
            m[K_INH] += inhib;
            m[K_P16] += p16;
            @(posedge clk_in);
            if (n == t_at) term <= 1'b1;
        end while (n < 80 && !(n > 2 && ready === 1'b1 && ce_n === 1'b1));
        done = (n < 80);
        if (!done) fails++;
        @(posedge clk_in);
        term <= 1'b0;
    endtask
    // ========================================================================
    // Clock, watchdog and tests
    // ========================================================================
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
    initial begin
        fails = 0;
        n_compared = 0;
        reset_n_in = 1'b0;
        cfg = 9'h1CB;
        last_sel = 1'b0;
        term = 1'b0;
        rq = '0;
        do_reset(cs_burst_pkg::CFG_DEFAULT);
        for (int w = 0; w < 8; w++) begin
            access(mk(5'h02, cs_burst_pkg::INTERFACE_TYPE_FIELD_B1_AOE, 1'b1, w[2:0]), 0);
            check(m[K_FIRST], w + 3);
            check(m[K_ACK], 1);
            check(m[K_WE], 0);
        end
        access(mk(5'h12, cs_burst_pkg::INTERFACE_TYPE_FIELD_B1_AOE, 1'b1, 3'h1), 0);
        check({m[K_WE] > 0, m[K_OE] == 0}, 2'h3);
        access(mk(5'h0A, cs_burst_pkg::INTERFACE_TYPE_FIELD_B1_SOE, 1'b1, 3'h0), 0);
        check(m[K_ACK], 4);
        check(m[K_BD] > 0, 1);
        check(m[K_OEF] > m[K_CEF], 1);
        access(mk(5'h08, cs_burst_pkg::INTERFACE_TYPE_FIELD_B1_AOE, 1'b1, 3'h0), 0);
        check({m[K_INH] > 0, m[K_ACK]}, 33'h1_0000_0001);
        access(mk(5'h01, cs_burst_pkg::INTERFACE_TYPE_FIELD_ASYNC, 1'b1, 3'h1), 0);
        check({m[K_P16] > 0, m[K_ACK]}, 33'h1_0000_0001);
        access(mk(5'h0B, cs_burst_pkg::INTERFACE_TYPE_FIELD_B1_AOE, 1'b1, 3'h0), 12);
        check({done, m[K_OE] >= 10}, 2'h3);
        @(posedge clk_in);
        last_sel <= 1'b1;
        access(mk(5'h0A, cs_burst_pkg::INTERFACE_TYPE_FIELD_B2, 1'b1, 3'h3), 0);
        check(m[K_ST], 1);
        check(m[K_CE] >= m[K_FIRST], 1);
        check(m[K_ACK], 4);
        check(m[K_BD], 1);
        access(mk(5'h14, cs_burst_pkg::INTERFACE_TYPE_FIELD_ASYNC, 1'b0, 3'h0), 0);
        check({m[K_WE], m[K_OE] > 0}, 17'h1);
        check(m[K_FIRST], 10);
        access(mk(5'h00, cs_burst_pkg::INTERFACE_TYPE_FIELD_ASYNC, 1'b0, 3'h0), 0);
        check(done, 1);
        check(m[K_ACK], 0);
        do_reset(9'h000);
        access(mk(5'h04, cs_burst_pkg::INTERFACE_TYPE_FIELD_ASYNC, 1'b1, 3'h5), 0);
        check(m[K_FIRST], 3);
        do_reset(9'h014);
        report_and_stop();
    end
endmodule // tb_top

// *** hdl/chip_select_burst_interface.sv ***
// Chip-select strobe sequencer for synchronous and burst memory regions.
//
// Operation
// - Latch-enable memories are driven only with unlatched asynchronous sequences.
// - Synchronous output enable asserts at least one cycle after chip enable.
// - Type 1 burst gates data with enables and drives burst-in-progress.
// - Type 2 burst keeps chip enable through latency, supplies start strobe.
// - Pin-select bit picks last-beat timing when 1, burst-in-progress when 0.
// - Burst addresses need not stay valid after the latching edge.
// - Single word to burstable region asserts enable for one word.
// - Fixed burst to burstable region holds enable for four beats.
// - Burst to non-burstable region flags inhibit, runs single word.
// - Small-port fixed burst holds enable until the bus interface terminates.
// - Small-port single word does one access and reports 16-bit port.
// - Reset configuration bit 0 selects chip-select pins (1) or address.
// - Reset configuration bit 2 selects burst type 1 or type 2.
// - Bits 3 and 4 set boot interface type and boot port width.
// - Bits 6:8 give boot acknowledge delay, zero to seven waits.
// - External boot asserts chip enable and output enable, never write.
// - While reset is asserted all chip selects are driven negated.
// - With acknowledge enabled the unit generates transfer acknowledge.
`timescale 1ns/1ps
module chip_select_burst_interface (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [8:0] reset_config_in,
    input wire logic last_pin_select_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_burst_in,
    input wire logic req_boot_in,
    input wire logic [3:0] interface_type_field_in,
    input wire logic req_burstable_in,
    input wire logic req_small_port_in,
    input wire logic internal_ack_enable_in,
    input wire logic [2:0] req_waits_in,
    input wire logic ebi_terminate_in,
    input wire logic ext_ack_n_in,
    output logic req_ready_out,
    output logic chip_enable_n_out,
    output logic output_enable_n_out,
    output logic write_enable_n_out,
    output logic burst_in_progress_n_out,
    output logic transfer_start_n_out,
    output logic transfer_ack_n_out,
    output logic burst_inhibit_out,
    output logic port16_out,
    output logic cs_pins_select_out,
    output logic burst_type2_out,
    output logic [3:0] boot_interface_type_field_out,
    output logic boot_port32_out,
    output logic [2:0] boot_waits_out
);
    // ========================================================================
    // State
    // ========================================================================
    typedef enum logic [1:0] {IDLE, ADDR, WAITS, DATA} phase_t;

    typedef struct packed {
        phase_t phase;
        cs_burst_pkg::access_req_t req;
        cs_burst_pkg::strobe_out_t pins;
        logic [2:0] wait_cnt;
        logic [2:0] beat_cnt;
        logic [8:0] cfg;
        logic ack_sync1;
        logic ack_sync2;
    } state_t;

    state_t s_q;
    state_t s_d;

    function automatic logic is_burst_type(input logic [3:0] it);
        return it == cs_burst_pkg::INTERFACE_TYPE_FIELD_B1_AOE ||
            it == cs_burst_pkg::INTERFACE_TYPE_FIELD_B1_SOE ||
            it == cs_burst_pkg::INTERFACE_TYPE_FIELD_B2;
    endfunction

    function automatic logic is_sync_oe(input logic [3:0] it);
        return it == cs_burst_pkg::INTERFACE_TYPE_FIELD_SYNC_SOE ||
            it == cs_burst_pkg::INTERFACE_TYPE_FIELD_B1_SOE;
    endfunction

    function automatic cs_burst_pkg::strobe_out_t idle_pins();
        cs_burst_pkg::strobe_out_t p;
        p = '1;
        p.burst_inhibit = 1'b0;
        p.port16 = 1'b0;
        return p;
    endfunction

    logic multi_beat;
    logic last_beat;
    logic ack_done;
    assign multi_beat = s_q.req.burst && s_q.req.burstable;
    // Small-port bursts hold the strobes until the bus interface ends the burst.
    assign last_beat = (s_q.req.small_port && multi_beat) ?
        ebi_terminate_in :
        (!multi_beat || ebi_terminate_in ||
        s_q.beat_cnt == cs_burst_pkg::BURST_BEATS - cs_burst_pkg::ONE_BEAT);
    assign ack_done = s_q.req.ack_en ? 1'b1 : !s_q.ack_sync2;

    // ========================================================================
    // Next-state logic
    // ========================================================================
    always_comb begin
        s_d = s_q;
        s_d.ack_sync1 = ext_ack_n_in;
        s_d.ack_sync2 = s_q.ack_sync1;
        s_d.pins.start_n = 1'b1;
        s_d.pins.ack_n = 1'b1;
        case (s_q.phase)
            IDLE: begin
                if (req_valid_in) begin
                    // Everything the access needs is captured here, so the
                    // address may move on after this latching edge.
                    s_d.req.valid = 1'b1;
                    s_d.req.write = req_write_in && !req_boot_in;
                    s_d.req.burst = req_burst_in;
                    s_d.req.boot = req_boot_in;
                    s_d.req.small_port = req_small_port_in;
                    s_d.req.ack_en = internal_ack_enable_in;
                    s_d.req.interface_type_field = interface_type_field_in;
                    s_d.req.waits = req_waits_in;
                    if (req_boot_in) begin
                        // Boot strobes come from the captured reset word.
                        s_d.req.interface_type_field = boot_interface_type_field_out;
                        s_d.req.small_port = !boot_port32_out;
                        s_d.req.waits = boot_waits_out;
                        s_d.req.ack_en = 1'b1;
                    end
                    // Latch-enable parts use the plain asynchronous path.
                    s_d.req.burstable = req_burstable_in &&
                        is_burst_type(s_d.req.interface_type_field);
                    s_d.pins.ce_n = 1'b0;
                    s_d.pins.start_n = 1'b0;
                    s_d.pins.burst_inhibit = req_burst_in &&
                        !s_d.req.burstable;
                    s_d.pins.port16 = s_d.req.small_port;
                    s_d.wait_cnt = '0;
                    s_d.beat_cnt = '0;
                    s_d.phase = ADDR;
                    if (!is_sync_oe(s_d.req.interface_type_field)) begin
                        s_d.pins.oe_n = s_d.req.write;
                        s_d.pins.we_n = !s_d.req.write;
                    end
                end
            end
            ADDR: begin
                // Synchronous enables follow chip enable by a cycle.
                s_d.pins.oe_n = s_q.req.write;
                s_d.pins.we_n = !s_q.req.write;
                s_d.pins.burst_in_progress_n_last_n = !(multi_beat &&
                    !last_pin_select_in);
                s_d.phase = WAITS;
            end
            WAITS: begin
                // Chip enable stays low through the whole latency.
                if (s_q.wait_cnt >= s_q.req.waits && ack_done) begin
                    s_d.phase = DATA;
                    s_d.pins.ack_n = !s_q.req.ack_en;
                    if (last_beat && last_pin_select_in && multi_beat) begin
                        s_d.pins.burst_in_progress_n_last_n = 1'b0;
                    end
                end else begin
                    s_d.wait_cnt = s_q.wait_cnt + 3'h1;
                end
            end
            DATA: begin
                if (last_beat) begin
                    s_d.pins = idle_pins();
                    s_d.req.valid = 1'b0;
                    s_d.phase = IDLE;
                end else begin
                    s_d.beat_cnt = s_q.beat_cnt + 3'h1;
                    s_d.pins.ack_n = !s_q.req.ack_en;
                    if (s_q.beat_cnt == cs_burst_pkg::BURST_BEATS -
                        3'h2 && !s_q.req.small_port) begin
                        // Burst-in-progress drops for the final beat.
                        s_d.pins.burst_in_progress_n_last_n = !last_pin_select_in ?
                            1'b1 : 1'b0;
                    end
                end
            end
            default: begin
                s_d.phase = IDLE;
            end
        endcase
    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
            s_q.phase <= IDLE;
            s_q.pins <= idle_pins();
            s_q.cfg <= cs_burst_pkg::CFG_DEFAULT;
            s_q.ack_sync1 <= 1'b1;
            s_q.ack_sync2 <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // The configuration word is sampled on the first edge after release.
    logic cfg_taken_q;
    logic [8:0] cfg_q;
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cfg_taken_q <= 1'b0;
            cfg_q <= cs_burst_pkg::CFG_DEFAULT;
        end else if (!cfg_taken_q) begin
            cfg_taken_q <= 1'b1;
            cfg_q <= reset_config_in;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign req_ready_out = s_q.phase == IDLE && cfg_taken_q;
    assign chip_enable_n_out = s_q.pins.ce_n;
    assign output_enable_n_out = s_q.pins.oe_n;
    assign write_enable_n_out = s_q.pins.we_n;
    assign burst_in_progress_n_out = s_q.pins.burst_in_progress_n_last_n;
    assign transfer_start_n_out = s_q.pins.start_n;
    assign transfer_ack_n_out = s_q.pins.ack_n;
    assign burst_inhibit_out = s_q.pins.burst_inhibit;
    assign port16_out = s_q.pins.port16;
    assign cs_pins_select_out = cfg_q[cs_burst_pkg::CFG_PIN_FN];
    assign burst_type2_out = cfg_q[cs_burst_pkg::CFG_BURST_TYPE];
    assign boot_interface_type_field_out = cfg_q[cs_burst_pkg::CFG_BOOT_INTERFACE_TYPE_FIELD] ?
        cs_burst_pkg::INTERFACE_TYPE_FIELD_ASYNC : cs_burst_pkg::INTERFACE_TYPE_FIELD_B2;
    assign boot_port32_out = cfg_q[cs_burst_pkg::CFG_BOOT_PORT];
    assign boot_waits_out = cfg_q[cs_burst_pkg::CFG_WAIT_LO +: 3];

    // ========================================================================
    // Checks
    // ========================================================================
    sequence ce_fall_s;
        $fell(chip_enable_n_out);
    endsequence

    // Looking one edge ahead avoids reading state before the first reset.
    reset_negated_a: assert property (@(posedge clk_in)
        !reset_n_in |=> chip_enable_n_out)
        else $error("Chip select asserted after reset.");

    sync_oe_gap_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        ce_fall_s ##0 is_sync_oe(s_q.req.interface_type_field) |-> output_enable_n_out)
        else $error("Synchronous enable came with chip enable.");

    boot_no_write_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        s_q.req.boot && s_q.req.valid |-> write_enable_n_out)
        else $error("Write enable on boot access.");

    start_with_ce_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        !transfer_start_n_out |-> ce_fall_s)
        else $error("Start strobe without chip enable edge.");

    inhibit_flag_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        burst_inhibit_out |-> s_q.req.burst && !s_q.req.burstable)
        else $error("Burst inhibit without cause.");

    port16_flag_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        s_q.req.valid |-> port16_out == s_q.req.small_port)
        else $error("Port width report wrong.");

    single_word_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        s_q.phase == DATA && !multi_beat |=> s_q.phase == IDLE)
        else $error("Single word held too long.");

    four_beats_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        s_q.phase == DATA && multi_beat && !s_q.req.small_port
        |-> s_q.beat_cnt < cs_burst_pkg::BURST_BEATS)
        else $error("Burst exceeded four beats.");

    ack_internal_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        !transfer_ack_n_out |-> s_q.req.ack_en)
        else $error("Acknowledge from unit without enable.");

    boot_cfg_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        s_q.req.boot && s_q.req.valid
        |-> s_q.req.small_port == !boot_port32_out)
        else $error("Boot port width mismatch.");

    sequence burst_data_s;
        s_q.phase == DATA && multi_beat;
    endsequence

    start_pulse_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        !transfer_start_n_out |=> transfer_start_n_out)
        else $error("Start strobe longer than one cycle.");

    ce_latency_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        s_q.phase == WAITS |-> !chip_enable_n_out)
        else $error("Chip enable dropped during latency.");

    pin_timing_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        !burst_in_progress_n_out |-> multi_beat)
        else $error("Burst pin asserted outside a burst.");

    // The bus interface alone decides how long a small-port burst runs.
    small_hold_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        burst_data_s ##0 s_q.req.small_port && !ebi_terminate_in
        |=> s_q.phase == DATA)
        else $error("Small-port burst ended before termination.");

    inhibit_single_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        burst_inhibit_out && s_q.phase == DATA |=> s_q.phase == IDLE)
        else $error("Inhibited burst ran past one word.");

    read_gate_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        !output_enable_n_out |-> !s_q.req.write)
        else $error("Output enable on a write.");

    write_gate_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        !write_enable_n_out |-> s_q.req.write)
        else $error("Write enable on a read.");
endmodule // chip_select_burst_interface

// *** hdl/cs_burst_pkg.sv ***
// Package with constants and carrier types for the chip-select burst unit.
package cs_burst_pkg;
    // ========================================================================
    // Interface-type encodings
    // ========================================================================
    localparam logic [3:0] INTERFACE_TYPE_FIELD_ASYNC = 4'h1;
    localparam logic [3:0] INTERFACE_TYPE_FIELD_SYNC_AOE = 4'h2;
    localparam logic [3:0] INTERFACE_TYPE_FIELD_SYNC_SOE = 4'h3;
    localparam logic [3:0] INTERFACE_TYPE_FIELD_B1_AOE = 4'h5;
    localparam logic [3:0] INTERFACE_TYPE_FIELD_B1_SOE = 4'h7;
    localparam logic [3:0] INTERFACE_TYPE_FIELD_B2 = 4'h8;
    // ========================================================================
    // Reset configuration word fields
    // ========================================================================
    localparam int CFG_PIN_FN = 0;
    localparam int CFG_BURST_TYPE = 2;
    localparam int CFG_BOOT_INTERFACE_TYPE_FIELD = 3;
    localparam int CFG_BOOT_PORT = 4;
    localparam int CFG_WAIT_LO = 6;
    localparam logic [8:0] CFG_DEFAULT = 9'h1CB;
    // ========================================================================
    // Burst and boot geometry
    // ========================================================================
    localparam logic [2:0] BURST_BEATS = 3'h4;
    localparam int BOOT_RANGE_BITS = 20;
    localparam logic [2:0] ONE_BEAT = 3'h1;

    typedef struct packed {
        logic valid;
        logic write;
        logic burst;
        logic boot;
        logic [3:0] interface_type_field;
        logic burstable;
        logic small_port;
        logic ack_en;
        logic [2:0] waits;
    } access_req_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic burst_in_progress_n_last_n;
        logic start_n;
        logic ack_n;
        logic burst_inhibit;
        logic port16;
    } strobe_out_t;
endpackage
